// ==== rtl/dcd_pkg.sv ====
// Purpose: shared constants, command type and decode helpers of the DRAM command decoder
// Assumes: x18 organisation, eight banks, non-multiplexed address
// Notes: mode register field positions below are local choices
package dcd_pkg;
    localparam int DCD_ADDR_W = 22;
    localparam int DCD_BANK_W = 3;
    localparam int DCD_DATA_W = 18;
    localparam int DCD_MODE_W = 18;
    localparam int DCD_ROW_W = 13;
    localparam int DCD_LAT_W = 4;
    localparam int DCD_CNT_W = 5;

    // mode register fields
    localparam int DCD_CFG_LSB = 0;
    localparam int DCD_BL_LSB = 3;
    localparam logic [DCD_MODE_W-1:0] DCD_MODE_RESET = 18'h00000;
    localparam logic [1:0] DCD_BL2_CODE = 2'h0;
    localparam logic [1:0] DCD_BL4_CODE = 2'h1;
    localparam logic [1:0] DCD_BL8_CODE = 2'h2;

    // read latency per configuration, write latency one more
    localparam logic [DCD_LAT_W-1:0] DCD_RL_CFG1 = 4'h4;
    localparam logic [DCD_LAT_W-1:0] DCD_RL_CFG2 = 4'h6;
    localparam logic [DCD_LAT_W-1:0] DCD_RL_CFG3 = 4'h8;
    localparam logic [DCD_LAT_W-1:0] DCD_RL_CFG4 = 4'h3;
    localparam logic [DCD_LAT_W-1:0] DCD_RL_CFG5 = 4'h5;
    localparam logic [DCD_LAT_W-1:0] DCD_WL_EXTRA = 4'h1;

    // used address bits per burst length
    localparam logic [DCD_ADDR_W-1:0] DCD_AMASK_BL2 = 22'h1fffff;
    localparam logic [DCD_ADDR_W-1:0] DCD_AMASK_BL4 = 22'h0fffff;
    localparam logic [DCD_ADDR_W-1:0] DCD_AMASK_BL8 = 22'h07ffff;
    localparam logic [DCD_MODE_W-1:0] DCD_MODE_BITS = 18'h3ffff;

    typedef enum logic [2:0] {DCD_CMD_IDLE, DCD_CMD_MODE, DCD_CMD_READ, DCD_CMD_WRITE, DCD_CMD_RENEW} dcd_cmd_t;

    function automatic dcd_cmd_t dcd_decode(input logic cs_n, input logic we_n, input logic rr_n);
        if (cs_n) begin
            return DCD_CMD_IDLE;
        end
        case ({we_n, rr_n})
            2'h0: return DCD_CMD_MODE;
            2'h3: return DCD_CMD_READ;
            2'h1: return DCD_CMD_WRITE;
            2'h2: return DCD_CMD_RENEW;
            default: return DCD_CMD_IDLE;
        endcase
    endfunction : dcd_decode

    function automatic logic [DCD_LAT_W-1:0] dcd_read_lat(input logic [2:0] cfg);
        case (cfg)
            3'h0: return DCD_RL_CFG1;
            3'h1: return DCD_RL_CFG2;
            3'h2: return DCD_RL_CFG3;
            3'h3: return DCD_RL_CFG4;
            3'h4: return DCD_RL_CFG5;
            default: return DCD_RL_CFG1;
        endcase
    endfunction : dcd_read_lat

    function automatic logic [DCD_LAT_W-1:0] dcd_beats(input logic [1:0] code);
        case (code)
            DCD_BL4_CODE: return 4'h4;
            DCD_BL8_CODE: return 4'h8;
            default: return 4'h2;
        endcase
    endfunction : dcd_beats

    function automatic logic [DCD_ADDR_W-1:0] dcd_addr_mask(input logic [1:0] code);
        case (code)
            DCD_BL4_CODE: return DCD_AMASK_BL4;
            DCD_BL8_CODE: return DCD_AMASK_BL8;
            default: return DCD_AMASK_BL2;
        endcase
    endfunction : dcd_addr_mask
endpackage : dcd_pkg

// ==== rtl/dcd_burst.sv ====
// Purpose: burst timer, counts latency then marks one beat per clock
// Assumes: latency of at least 2, beats of at least 1
// Notes: a start while running is ignored
`timescale 1ns/1ps
module dcd_burst
    import dcd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // launch
    input wire logic start,
    input wire logic [DCD_LAT_W-1:0] latency,
    input wire logic [DCD_LAT_W-1:0] beats,
    // progress
    output logic active,
    output logic beat,
    output logic [DCD_LAT_W-1:0] beat_idx
);
    typedef enum logic {DCD_BURST_IDLE, DCD_BURST_RUN} dcd_burst_state_t;

    dcd_burst_state_t state, next_state;
    logic [DCD_CNT_W-1:0] cnt, next_cnt;
    logic [DCD_LAT_W-1:0] lat_q, next_lat_q;
    logic [DCD_LAT_W-1:0] beats_q, next_beats_q;
    logic [DCD_CNT_W-1:0] first_beat;
    logic [DCD_CNT_W-1:0] offset;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_lat_q = lat_q;
        next_beats_q = beats_q;
        // cnt equals edges since the command edge; beat k sits on edge latency+k
        first_beat = DCD_CNT_W'({1'b0, lat_q} - 5'h01);
        offset = cnt - first_beat;
        active = (state == DCD_BURST_RUN);
        beat = active && (cnt >= first_beat);
        beat_idx = offset[DCD_LAT_W-1:0];
        case (state)
            DCD_BURST_IDLE: begin
                if (start) begin
                    next_state = DCD_BURST_RUN;
                    next_cnt = 5'h01;
                    next_lat_q = latency;
                    next_beats_q = beats;
                end
            end
            DCD_BURST_RUN: begin
                next_cnt = cnt + 5'h01;
                if (beat && (beat_idx == beats_q - 4'h1)) begin
                    next_state = DCD_BURST_IDLE;
                end
            end
            default: next_state = DCD_BURST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= DCD_BURST_IDLE;
            cnt <= 5'h00;
            lat_q <= 4'h0;
            beats_q <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            lat_q <= next_lat_q;
            beats_q <= next_beats_q;
        end
    end
endmodule : dcd_burst

// ==== rtl/dcd_command_decoder.sv ====
// Purpose: command front end and data path of an eight-bank burst DRAM
// Assumes: controller keeps mode load, spacing and refresh duties
// Notes: array holds only ARRAY_BITS low address bits per bank
`timescale 1ns/1ps
module dcd_command_decoder
    import dcd_pkg::*;
#(
    parameter int ARRAY_BITS = 8
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // command inputs
    input wire logic chip_select_n,
    input wire logic write_enable_n,
    input wire logic row_renew_n,
    input wire logic [DCD_ADDR_W-1:0] address,
    input wire logic [DCD_BANK_W-1:0] bank_select,
    // data lines, split into in, out and enable
    input wire logic [DCD_DATA_W-1:0] data_in,
    input wire logic write_mask,
    output logic [DCD_DATA_W-1:0] data_out,
    output logic data_oe,
    // status
    output logic [DCD_MODE_W-1:0] mode_reg,
    output logic refresh_pulse,
    output logic [DCD_BANK_W-1:0] refresh_bank,
    output logic [DCD_ROW_W-1:0] refresh_row
);
    localparam int IDX_W = DCD_BANK_W + ARRAY_BITS;
    localparam int NBANK = 1 << DCD_BANK_W;

    function automatic logic [IDX_W-1:0] word_index(input logic [DCD_BANK_W-1:0] bank,
                                                   input logic [DCD_ADDR_W-1:0] addr,
                                                   input logic [DCD_LAT_W-1:0] idx);
        logic [ARRAY_BITS-1:0] low;
        low = addr[ARRAY_BITS-1:0] + ARRAY_BITS'(idx);
        return {bank, low};
    endfunction : word_index

    dcd_cmd_t cmd_q, next_cmd_q;
    logic [DCD_ADDR_W-1:0] addr_q, next_addr_q;
    logic [DCD_BANK_W-1:0] bank_q, next_bank_q;
    logic [DCD_MODE_W-1:0] next_mode_reg;
    logic next_refresh_pulse;
    logic [DCD_BANK_W-1:0] next_refresh_bank;
    logic [DCD_ROW_W-1:0] next_refresh_row;
    logic [DCD_ROW_W-1:0] renew_row [0:NBANK-1];
    logic [DCD_ROW_W-1:0] next_renew_row [0:NBANK-1];
    logic [DCD_ADDR_W-1:0] rd_addr, next_rd_addr, wr_addr, next_wr_addr;
    logic [DCD_BANK_W-1:0] rd_bank, next_rd_bank, wr_bank, next_wr_bank;
    logic [DCD_DATA_W-1:0] next_data_out;
    logic next_data_oe;
    logic [DCD_DATA_W-1:0] mem [0:(1 << IDX_W)-1];

    logic [DCD_LAT_W-1:0] rd_lat, wr_lat, burst_beats;
    logic [DCD_ADDR_W-1:0] addr_mask;
    logic rd_start, wr_start;
    logic rd_active, rd_beat, wr_active, wr_beat;
    logic [DCD_LAT_W-1:0] rd_idx, wr_idx;
    logic [IDX_W-1:0] rd_index, wr_index;

    // input sampling and decode
    always_comb begin
        next_cmd_q = dcd_decode(chip_select_n, write_enable_n, row_renew_n);
        next_addr_q = address;
        next_bank_q = bank_select;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= DCD_CMD_IDLE;
            addr_q <= 22'h000000;
            bank_q <= 3'h0;
        end else begin
            cmd_q <= next_cmd_q;
            addr_q <= next_addr_q;
            bank_q <= next_bank_q;
        end
    end

    // burst timing from the mode register
    always_comb begin
        rd_lat = dcd_read_lat(mode_reg[DCD_CFG_LSB +: 3]);
        wr_lat = rd_lat + DCD_WL_EXTRA;
        burst_beats = dcd_beats(mode_reg[DCD_BL_LSB +: 2]);
        addr_mask = dcd_addr_mask(mode_reg[DCD_BL_LSB +: 2]);
        // idle launches nothing; running bursts continue on their own
        rd_start = (cmd_q == DCD_CMD_READ) && !rd_active;
        wr_start = (cmd_q == DCD_CMD_WRITE) && !wr_active;
    end

    dcd_burst u_rd_burst (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(rd_start),
        .latency(rd_lat),
        .beats(burst_beats),
        .active(rd_active),
        .beat(rd_beat),
        .beat_idx(rd_idx)
    );

    dcd_burst u_wr_burst (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(wr_start),
        .latency(wr_lat),
        .beats(burst_beats),
        .active(wr_active),
        .beat(wr_beat),
        .beat_idx(wr_idx)
    );

    // mode load, refresh and burst address capture
    always_comb begin
        next_mode_reg = mode_reg;
        next_refresh_pulse = 1'b0;
        next_refresh_bank = refresh_bank;
        next_refresh_row = refresh_row;
        next_renew_row = renew_row;
        next_rd_addr = rd_addr;
        next_rd_bank = rd_bank;
        next_wr_addr = wr_addr;
        next_wr_bank = wr_bank;
        case (cmd_q)
            DCD_CMD_MODE: next_mode_reg = addr_q[DCD_MODE_W-1:0];
            DCD_CMD_RENEW: begin
                // row from the bank's own counter, address ignored
                next_refresh_pulse = 1'b1;
                next_refresh_bank = bank_q;
                next_refresh_row = renew_row[bank_q];
                next_renew_row[bank_q] = renew_row[bank_q] + 13'h0001;
            end
            default: next_refresh_pulse = 1'b0;
        endcase
        if (rd_start) begin
            next_rd_addr = addr_q & addr_mask;
            next_rd_bank = bank_q;
        end
        if (wr_start) begin
            next_wr_addr = addr_q & addr_mask;
            next_wr_bank = bank_q;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= DCD_MODE_RESET;
            refresh_pulse <= 1'b0;
            refresh_bank <= 3'h0;
            refresh_row <= 13'h0000;
            for (int b = 0; b < NBANK; b++) begin
                renew_row[b] <= 13'h0000;
            end
            rd_addr <= 22'h000000;
            rd_bank <= 3'h0;
            wr_addr <= 22'h000000;
            wr_bank <= 3'h0;
        end else begin
            mode_reg <= next_mode_reg;
            refresh_pulse <= next_refresh_pulse;
            refresh_bank <= next_refresh_bank;
            refresh_row <= next_refresh_row;
            renew_row <= next_renew_row;
            rd_addr <= next_rd_addr;
            rd_bank <= next_rd_bank;
            wr_addr <= next_wr_addr;
            wr_bank <= next_wr_bank;
        end
    end

    // data path
    always_comb begin
        rd_index = word_index(rd_bank, rd_addr, rd_idx);
        wr_index = word_index(wr_bank, wr_addr, wr_idx);
        next_data_oe = rd_beat;
        next_data_out = rd_beat ? mem[rd_index] : data_out;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= 18'h00000;
            data_oe <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe <= next_data_oe;
        end
    end

    // array has no reset; masked words keep their contents
    always_ff @(posedge clock) begin
        if (wr_beat && !write_mask) begin
            mem[wr_index] <= data_in;
        end
    end

    sample_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!chip_select_n && !write_enable_n && !row_renew_n) |=> (cmd_q == DCD_CMD_MODE))
        else $error("mode load strobes not registered as mode load");
    deselect_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
        chip_select_n |=> (cmd_q == DCD_CMD_IDLE))
        else $error("command accepted while deselected");
    idle_nostart_a: assert property (@(posedge clock) disable iff (sys_rst)
        (cmd_q == DCD_CMD_IDLE) |=> !$rose(rd_active) && !$rose(wr_active) && !refresh_pulse)
        else $error("idle command started an operation");
    mode_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        (cmd_q == DCD_CMD_MODE) |=> (mode_reg == ($past(addr_q) & 22'h03ffff)))
        else $error("mode register not loaded from low address bits");
    renew_bank_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!chip_select_n && write_enable_n && !row_renew_n) |=> ##1 refresh_pulse
        && (refresh_bank == $past(bank_select, 2)))
        else $error("refresh missing or wrong bank");
    addr_width_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_start |=> ((rd_addr & ~$past(addr_mask)) == 22'h000000))
        else $error("unused address bits kept for read burst");
    write_store_a: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_beat && !write_mask) |=> (mem[$past(wr_index)] == $past(data_in)))
        else $error("unmasked write word not stored");
    write_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_beat && write_mask) |=> (mem[$past(wr_index)] == $past(mem[wr_index])))
        else $error("masked write word changed the array");
    read_burst_a: assert property (@(posedge clock) disable iff (sys_rst)
        (rd_start && (rd_lat == 4'h4) && (burst_beats == 4'h2))
        |-> ##4 data_oe ##1 data_oe ##1 !data_oe)
        else $error("read burst timing wrong for latency 4 burst 2");
endmodule : dcd_command_decoder

// ==== bench/dcd_ctl_model.sv ====
// Purpose: memory controller model driving commands and write words
// Assumes: caller keeps command spacing of reads and writes
// Notes: after the time-zero defaults, outputs change only by non-blocking assignment at a rising edge
`timescale 1ns/1ps
module dcd_ctl_model
    import dcd_pkg::*;
#(
    parameter int MODE_WAIT = 6
)
(
    // clock
    input wire logic clock,
    // command strobes and address
    output logic chip_select_n,
    output logic write_enable_n,
    output logic row_renew_n,
    output logic [DCD_ADDR_W-1:0] address,
    output logic [DCD_BANK_W-1:0] bank_select,
    // write data side of the data lines
    output logic [DCD_DATA_W-1:0] wr_data,
    output logic wr_oe,
    output logic write_mask
);
    initial begin
        chip_select_n = 1'b1;
        write_enable_n = 1'b1;
        row_renew_n = 1'b1;
        address = '0;
        bank_select = '0;
        wr_data = '0;
        wr_oe = 1'b0;
        write_mask = 1'b1;
    end

    // command held over one whole cycle around its edge
    task automatic issue(input logic we_n, input logic rr_n, input logic [DCD_ADDR_W-1:0] a,
                         input logic [DCD_BANK_W-1:0] b);
        @(posedge clock);
        chip_select_n <= 1'b0;
        write_enable_n <= we_n;
        row_renew_n <= rr_n;
        address <= a;
        bank_select <= b;
        @(posedge clock);
        chip_select_n <= 1'b1;
    endtask : issue

    // deselected cycle with garbage on the other command inputs, data side from the arguments
    task automatic idle_cycle(input logic oe, input logic [DCD_DATA_W-1:0] d, input logic m);
        @(posedge clock);
        chip_select_n <= 1'b1;
        write_enable_n <= 1'($urandom);
        row_renew_n <= 1'($urandom);
        address <= 22'($urandom);
        bank_select <= 3'($urandom);
        wr_oe <= oe;
        wr_data <= d;
        write_mask <= m;
    endtask : idle_cycle

    // quiet time after a mode load; loads only issued with every bank idle
    task automatic settle();
        repeat (MODE_WAIT) idle_cycle(1'b0, 18'($urandom), 1'($urandom));
    endtask : settle
endmodule : dcd_ctl_model

// ==== bench/dcd_command_decoder_tb_top.sv ====
// Purpose: self-checking bench of the command decoder against an associative array memory model
// Assumes: eight address bits kept per bank
// Notes: released data lines show the inverse of their last level
`timescale 1ns/1ps
module dcd_command_decoder_tb_top;
    import dcd_pkg::*;
    logic clock, sys_rst, chip_select_n, write_enable_n, row_renew_n, write_mask, wr_oe, data_oe, refresh_pulse;
    logic [DCD_ADDR_W-1:0] address, a;
    logic [DCD_BANK_W-1:0] bank_select, refresh_bank, b;
    logic [DCD_DATA_W-1:0] wr_data, data_out, mode_reg, dq, bus_last;
    logic [DCD_ROW_W-1:0] refresh_row;
    logic [DCD_DATA_W-1:0] mem [int];
    int mismatches, tests_run;
    int rows [8];
    int rl_tab [5];
    int bl_tab [3];

    assign dq = data_oe ? data_out : (wr_oe ? wr_data : ~bus_last);
    // bus keeper starts after reset so the released lines never go unknown
    always @(posedge clock) begin
        if (!sys_rst) bus_last <= dq;
    end

    dcd_ctl_model #(.MODE_WAIT(6)) ctl (.clock(clock), .chip_select_n(chip_select_n),
        .write_enable_n(write_enable_n), .row_renew_n(row_renew_n), .address(address),
        .bank_select(bank_select), .wr_data(wr_data), .wr_oe(wr_oe), .write_mask(write_mask));
    dcd_command_decoder #(.ARRAY_BITS(8)) DUT (.clock(clock), .sys_rst(sys_rst),
        .chip_select_n(chip_select_n), .write_enable_n(write_enable_n), .row_renew_n(row_renew_n),
        .address(address), .bank_select(bank_select), .data_in(dq), .write_mask(write_mask),
        .data_out(data_out), .data_oe(data_oe), .mode_reg(mode_reg), .refresh_pulse(refresh_pulse),
        .refresh_bank(refresh_bank), .refresh_row(refresh_row));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic bad(input logic [DCD_DATA_W-1:0] got, input logic [DCD_DATA_W-1:0] exp);
        mismatches++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    endtask : bad

    task automatic check_word(input logic [DCD_DATA_W-1:0] got, input logic [DCD_DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) bad(got, exp);
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) bad({17'h0, got}, {17'h0, exp});
    endtask : check_bit

    task automatic check_ref(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) bad({2'h0, got}, {2'h0, exp});
    endtask : check_ref

    function automatic int key(input logic [2:0] kb, input logic [21:0] ka, input int k);
        return int'({kb, 8'(ka[7:0] + k)});
    endfunction : key

    // word k sampled at edge E+rl+1+k
    task automatic do_write(input int rl, input int bl, input bit use_mask);
        logic [DCD_DATA_W-1:0] d;
        logic m;
        ctl.issue(1'b0, 1'b1, a, b);
        for (int i = 1; i <= rl + bl; i++) begin
            d = 18'($urandom);
            m = use_mask ? 1'($urandom) : 1'b0;
            ctl.idle_cycle(i < rl + bl && i >= rl, d, m);
            if (i < rl + bl && i >= rl && !m) mem[key(b, a, i - rl)] = d;
        end
    endtask : do_write

    // garbage strobes with select high run alongside the burst
    task automatic do_read(input int rl, input int bl);
        logic on;
        ctl.issue(1'b1, 1'b1, a, b);
        for (int i = 1; i <= rl + bl; i++) begin
            ctl.idle_cycle(1'b0, 18'($urandom), 1'($urandom));
            #1;
            on = i >= rl && i < rl + bl;
            check_bit(data_oe, on);
            if (on) check_word(data_out, mem[key(b, a, i - rl)]);
        end
    endtask : do_read

    initial begin
        repeat (20000) @(posedge clock);
        bad(18'h0, 18'h1);
        print_verdict();
    end

    initial begin
        mismatches = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        bus_last = '0;
        void'($urandom(72));
        rl_tab = '{int'(DCD_RL_CFG1), int'(DCD_RL_CFG2), int'(DCD_RL_CFG3), int'(DCD_RL_CFG4), int'(DCD_RL_CFG5)};
        bl_tab = '{2, 4, 8};
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check_word(mode_reg, 18'h0);
        check_bit(data_oe, 1'b0);
        check_bit(refresh_pulse, 1'b0);
        check_ref({refresh_bank, refresh_row}, 16'h0);
        // reserved codes first (latency 4, burst 2), then every latency with every allowed burst length
        for (int cfg = -1; cfg < 5; cfg++) begin
            for (int bl = 0; bl < 4; bl++) begin
                if ((bl == 2 && (cfg == 0 || cfg == 3)) || ((cfg < 0) != (bl == 3))) continue;
                a = {4'($urandom), 13'h0, 2'(bl), 3'(cfg < 0 ? 5 + $urandom_range(2) : cfg)};
                ctl.issue(1'b0, 1'b0, a, 3'($urandom));
                ctl.idle_cycle(1'b0, 18'h0, 1'b0);
                #1;
                check_word(mode_reg, a[17:0]);
                ctl.settle();
                a = 22'($urandom);
                b = 3'($urandom);
                do_write(rl_tab[cfg < 0 ? 0 : cfg], bl_tab[bl % 3], 1'b0);
                do_write(rl_tab[cfg < 0 ? 0 : cfg], bl_tab[bl % 3], 1'b1);
                do_read(rl_tab[cfg < 0 ? 0 : cfg], bl_tab[bl % 3]);
            end
        end
        // refresh rows advance per bank
        for (int n = 0; n < 24; n++) begin
            b = 3'($urandom);
            ctl.issue(1'b1, 1'b0, 22'($urandom), b);
            ctl.idle_cycle(1'b0, 18'h0, 1'b0);
            #1;
            check_bit(refresh_pulse, 1'b1);
            check_ref({refresh_bank, refresh_row}, {b, 13'(rows[b])});
            rows[b]++;
            ctl.idle_cycle(1'b0, 18'h0, 1'b0);
            #1;
            check_bit(refresh_pulse, 1'b0);
        end
        // deselected cycles accept nothing
        repeat (32) begin
            ctl.idle_cycle(1'b0, 18'($urandom), 1'($urandom));
            #1;
            check_bit(refresh_pulse, 1'b0);
            check_bit(data_oe, 1'b0);
            check_word(mode_reg, {13'h0, 2'h2, 3'h4});
        end
        print_verdict();
    end
endmodule : dcd_command_decoder_tb_top
